/* design/atcs_map.svh */
// Purpose: Offsets, field positions, reset values and time tables of the
//          gain-control time-constant registers.
// Assumes: Times are whole milliseconds; decimation ratio is in half steps.
// Notes:   Definitions only.
//
// Contract
// - Left decay selection 0 uses older register 26 time; 1 uses own fields.
// - Left decay baseline codes 00..11 give 50, 150, 250, 350 ms.
// - Left decay multiplier code n scales the baseline by two to the n.
// - Left decay time from own fields is capped by the limit of the decimation ratio.
// - Right attack selection 0 uses older register 29 time; 1 uses own.
// - Right attack baseline codes 00..11 give 7, 8, 10, 11 ms.
// - Right attack multiplier code n scales the baseline by two to the n.
`ifndef ATCS_MAP_SVH
`define ATCS_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define ATCS_OFS_LEFT_DECAY   8'h68
`define ATCS_OFS_RIGHT_ATTACK 8'h69
`define ATCS_OFS_STATUS       8'h6a

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define ATCS_SEL_BIT   7
`define ATCS_BASE_HI   6
`define ATCS_BASE_LO   5
`define ATCS_MULT_HI   4
`define ATCS_MULT_LO   2
`define ATCS_CFG_RESET 8'h00

// ----------------------------------------------------------------------
// Baseline times in milliseconds
// ----------------------------------------------------------------------
`define ATCS_DECAY_BASE_0  16'h0032
`define ATCS_DECAY_BASE_1  16'h0096
`define ATCS_DECAY_BASE_2  16'h00fa
`define ATCS_DECAY_BASE_3  16'h015e
`define ATCS_ATTACK_BASE_0 16'h0007
`define ATCS_ATTACK_BASE_1 16'h0008
`define ATCS_ATTACK_BASE_2 16'h000a
`define ATCS_ATTACK_BASE_3 16'h000b

// ----------------------------------------------------------------------
// Decay limits in milliseconds per decimation ratio
// ----------------------------------------------------------------------
`define ATCS_LIMIT_1_0 16'h0fa0
`define ATCS_LIMIT_1_5 16'h15e0
`define ATCS_LIMIT_2_0 16'h1f40
`define ATCS_LIMIT_2_5 16'h2580
`define ATCS_LIMIT_3_X 16'h2bc0
`define ATCS_LIMIT_4_X 16'h3e80
`define ATCS_LIMIT_5_0 16'h4b00
`define ATCS_LIMIT_5_X 16'h5780

`endif

/* design/atcs_pkg.sv */
// Purpose: Types shared by the time-constant select block.
// Assumes: Constants live in atcs_map.svh.
// Notes:   Types only.
package atcs_pkg;

  typedef struct packed {
    logic [7:0]  left_cfg;
    logic [7:0]  right_cfg;
    logic [7:0]  rdata;
    logic [15:0] left_time;
    logic        left_own;
    logic        left_capped;
    logic [15:0] right_time;
    logic        right_own;
  } atcs_state_t;

  typedef enum logic [1:0] {
    ATCS_KIND_DECAY,
    ATCS_KIND_ATTACK
  } atcs_kind_t;

endpackage

/* design/atcs_calc_if.sv */
// Purpose: Carries one channel's configuration to the time calculator.
// Assumes: One calculator per channel.
// Notes:   No clocking; purely combinational traffic.
`timescale 1ns/1ps
`default_nettype none
interface atcs_calc_if;
  logic [7:0]  cfg;
  logic        limit_en;
  logic [15:0] limit_ms;
  logic [15:0] time_ms;
  logic        capped;

  modport req  (output cfg, output limit_en, output limit_ms,
                input time_ms, input capped);
  modport calc (input cfg, input limit_en, input limit_ms,
                output time_ms, output capped);
endinterface
`default_nettype wire

/* design/atcs_time_calc.sv */
// Purpose: Turns baseline and multiplier fields into a time in ms.
// Assumes: Kind selects the decay or attack baseline table.
// Notes:   Combinational; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
`include "atcs_map.svh"
module atcs_time_calc
  import atcs_pkg::*;
#(
  parameter atcs_kind_t KIND = ATCS_KIND_DECAY
) (
  atcs_calc_if.calc port  // Channel configuration and result.
);

  logic [1:0]  base_code;
  logic [2:0]  mult_code;
  logic [15:0] base_ms;
  logic [23:0] raw_ms;

  assign base_code = port.cfg[`ATCS_BASE_HI:`ATCS_BASE_LO];
  assign mult_code = port.cfg[`ATCS_MULT_HI:`ATCS_MULT_LO];

  always_comb begin
    if (KIND == ATCS_KIND_DECAY) begin
      case (base_code)
        2'h0:    base_ms = `ATCS_DECAY_BASE_0;
        2'h1:    base_ms = `ATCS_DECAY_BASE_1;
        2'h2:    base_ms = `ATCS_DECAY_BASE_2;
        default: base_ms = `ATCS_DECAY_BASE_3;
      endcase
    end else begin
      case (base_code)
        2'h0:    base_ms = `ATCS_ATTACK_BASE_0;
        2'h1:    base_ms = `ATCS_ATTACK_BASE_1;
        2'h2:    base_ms = `ATCS_ATTACK_BASE_2;
        default: base_ms = `ATCS_ATTACK_BASE_3;
      endcase
    end
  end

  // The widest product is 350 ms times 128, which needs 16 bits; the
  // extra headroom keeps the shift from ever wrapping.
  assign raw_ms = {8'h00, base_ms} << mult_code;

  always_comb begin
    port.capped  = 1'b0;
    port.time_ms = raw_ms[15:0];
    if (raw_ms[23:16] != 8'h00) begin
      port.time_ms = 16'hffff;
    end
    if (port.limit_en && (raw_ms > {8'h00, port.limit_ms})) begin
      port.capped  = 1'b1;
      port.time_ms = port.limit_ms;
    end
  end

endmodule
`default_nettype wire

/* design/atcs_top.sv */
// Purpose: Register bank that selects the record gain-control time
//          constants of the left decay and right attack paths.
// Assumes: Register port strobes are single cycle and never together.
// Notes:   Read data stand in the cycle after the read strobe only.
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "atcs_map.svh"
module atcs_top
  import atcs_pkg::*;
(
  input  wire logic        i_clk,                  // Core clock.
  input  wire logic        i_reset,                // Sync reset, high.
  input  wire logic [7:0]  i_addr,                 // Register offset.
  input  wire logic [7:0]  i_wdata,                // Write data.
  input  wire logic        i_wr,                   // Write strobe.
  input  wire logic        i_rd,                   // Read strobe.
  input  wire logic [3:0]  i_adc_decimation_ratio, // Ratio code, half steps.
  input  wire logic [15:0] i_legacy_left_decay,    // Older decay time, ms.
  input  wire logic [15:0] i_legacy_right_attack,  // Older attack time, ms.
  output logic      [7:0]  o_rdata,                // Read data.
  output logic      [15:0] o_left_decay_ms,        // Applied left decay.
  output logic             o_left_decay_own,       // Left uses own fields.
  output logic             o_left_decay_capped,    // Left decay limited.
  output logic      [15:0] o_right_attack_ms,      // Applied right attack.
  output logic             o_right_attack_own      // Right uses own fields.
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------

  atcs_state_t state;
  atcs_state_t next_state;

  atcs_calc_if left_if ();
  atcs_calc_if right_if ();

  logic [15:0] decay_limit;
  logic        wr_left;
  logic        wr_right;
  logic [7:0]  status_word;

  // ----------------------------------------------------------------------
  // Decay limit from the decimation ratio
  // ----------------------------------------------------------------------

  // Ratio code n stands for a ratio of 1 + n/2. Codes past ratio 6 are
  // not defined for the decimator; they get the widest limit so that a
  // stray code shortens only decays that software set above 22400 ms.
  always_comb begin
    case (i_adc_decimation_ratio)
      4'h0:    decay_limit = `ATCS_LIMIT_1_0;
      4'h1:    decay_limit = `ATCS_LIMIT_1_5;
      4'h2:    decay_limit = `ATCS_LIMIT_2_0;
      4'h3:    decay_limit = `ATCS_LIMIT_2_5;
      4'h4:    decay_limit = `ATCS_LIMIT_3_X;
      4'h5:    decay_limit = `ATCS_LIMIT_3_X;
      4'h6:    decay_limit = `ATCS_LIMIT_4_X;
      4'h7:    decay_limit = `ATCS_LIMIT_4_X;
      4'h8:    decay_limit = `ATCS_LIMIT_5_0;
      4'h9:    decay_limit = `ATCS_LIMIT_5_X;
      4'ha:    decay_limit = `ATCS_LIMIT_5_X;
      default: decay_limit = `ATCS_LIMIT_5_X;
    endcase
  end

  // ----------------------------------------------------------------------
  // Per-channel calculators
  // ----------------------------------------------------------------------

  assign left_if.cfg       = state.left_cfg;
  assign left_if.limit_en  = 1'b1;
  assign left_if.limit_ms  = decay_limit;

  assign right_if.cfg      = state.right_cfg;
  assign right_if.limit_en = 1'b0;
  assign right_if.limit_ms = 16'h0000;

  atcs_time_calc #(
    .KIND (ATCS_KIND_DECAY)
  ) u_left_calc (
    .port (left_if)
  );

  atcs_time_calc #(
    .KIND (ATCS_KIND_ATTACK)
  ) u_right_calc (
    .port (right_if)
  );

  // ----------------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------------

  assign wr_left  = i_wr && (i_addr == `ATCS_OFS_LEFT_DECAY);
  assign wr_right = i_wr && (i_addr == `ATCS_OFS_RIGHT_ATTACK);

  // The status word shows what the gain loops really run with, which can
  // differ from the stored fields while the limit is in force.
  assign status_word = {5'h00,
                        state.right_own,
                        state.left_own,
                        state.left_capped};

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------

  always_comb begin
    next_state = state;

    // Reserved low bits are stored as written; software is expected to
    // keep them at zero and the time logic never looks at them.
    if (wr_left) begin
      next_state.left_cfg = i_wdata;
    end
    if (wr_right) begin
      next_state.right_cfg = i_wdata;
    end

    // Read data are held for exactly one cycle after the strobe.
    next_state.rdata = 8'h00;
    if (i_rd) begin
      case (i_addr)
        `ATCS_OFS_LEFT_DECAY:   next_state.rdata = state.left_cfg;
        `ATCS_OFS_RIGHT_ATTACK: next_state.rdata = state.right_cfg;
        `ATCS_OFS_STATUS:       next_state.rdata = status_word;
        default:                next_state.rdata = 8'h00;
      endcase
    end

    // Left decay path.
    next_state.left_own = state.left_cfg[`ATCS_SEL_BIT];
    if (state.left_cfg[`ATCS_SEL_BIT]) begin
      next_state.left_time   = left_if.time_ms;
      next_state.left_capped = left_if.capped;
    end else begin
      next_state.left_time   = i_legacy_left_decay;
      next_state.left_capped = 1'b0;
    end

    // Right attack path.
    next_state.right_own = state.right_cfg[`ATCS_SEL_BIT];
    if (state.right_cfg[`ATCS_SEL_BIT]) begin
      next_state.right_time = right_if.time_ms;
    end else begin
      next_state.right_time = i_legacy_right_attack;
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------

  // Reset clears both configurations so the older registers drive the
  // gain loops; the applied times follow one cycle later.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state.left_cfg    <= `ATCS_CFG_RESET;
      state.right_cfg   <= `ATCS_CFG_RESET;
      state.rdata       <= 8'h00;
      state.left_time   <= 16'h0000;
      state.left_own    <= 1'b0;
      state.left_capped <= 1'b0;
      state.right_time  <= 16'h0000;
      state.right_own   <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------

  assign o_rdata             = state.rdata;
  assign o_left_decay_ms     = state.left_time;
  assign o_left_decay_own    = state.left_own;
  assign o_left_decay_capped = state.left_capped;
  assign o_right_attack_ms   = state.right_time;
  assign o_right_attack_own  = state.right_own;

endmodule
`default_nettype wire

/* sim/atcs_props.sv */
// Purpose: Port-level checks of the time-constant register bank.
// Assumes: A write lands in its register at the strobe edge.
// Notes:   Shadow copies of both registers feed the checks.
`timescale 1ns/1ps
`default_nettype none
module atcs_props (
  input wire logic        i_clk,
  input wire logic        i_reset,
  input wire logic [7:0]  i_addr,
  input wire logic [7:0]  i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [3:0]  i_adc_decimation_ratio,
  input wire logic [15:0] i_legacy_left_decay,
  input wire logic [15:0] i_legacy_right_attack,
  input wire logic [7:0]  o_rdata,
  input wire logic [15:0] o_left_decay_ms,
  input wire logic        o_left_decay_own,
  input wire logic        o_left_decay_capped,
  input wire logic [15:0] o_right_attack_ms,
  input wire logic        o_right_attack_own
);
  localparam int DB[4] = '{50, 150, 250, 350};
  localparam int AB[4] = '{7, 8, 10, 11};
  localparam int LIM[16] = '{4000, 5600, 8000, 9600, 11200, 11200, 16000,
    16000, 19200, 22400, 22400, 22400, 22400, 22400, 22400, 22400};
  logic [7:0] l_sh;
  logic [7:0] r_sh;
  int         l_raw;
  int         r_raw;
  int         l_lim;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      l_sh <= 8'h00;
      r_sh <= 8'h00;
    end else if (i_wr && i_addr == 8'h68) begin
      l_sh <= i_wdata;
    end else if (i_wr && i_addr == 8'h69) begin
      r_sh <= i_wdata;
    end
  end

  always_comb begin
    l_raw = DB[l_sh[6:5]] << l_sh[4:2];
    r_raw = AB[r_sh[6:5]] << r_sh[4:2];
    l_lim = LIM[i_adc_decimation_ratio];
  end

  // Outputs lag their causes by one edge, so the edge that leaves reset
  // still shows reset values; every check but rdata_idle_a skips it.
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  left_legacy_a: assert property (
    !$past(i_reset) && !o_left_decay_own
    |-> o_left_decay_ms == $past(i_legacy_left_decay))
    else $error("left decay does not follow the older time");
  left_sel_a: assert property (
    !$past(i_reset) |-> o_left_decay_own == $past(l_sh[7]))
    else $error("left own flag does not follow the select bit");
  left_time_a: assert property (
    !$past(i_reset) && o_left_decay_own && !o_left_decay_capped
    |-> o_left_decay_ms == $past(l_raw))
    else $error("left decay is not baseline times factor");
  left_cap_a: assert property (
    !$past(i_reset) && o_left_decay_capped |-> o_left_decay_ms == $past(l_lim)
    && $past(l_raw) > $past(l_lim) && $past(l_sh[7]))
    else $error("left decay limit misapplied");
  right_legacy_a: assert property (
    !$past(i_reset) && !o_right_attack_own
    |-> o_right_attack_ms == $past(i_legacy_right_attack))
    else $error("right attack does not follow the older time");
  right_sel_a: assert property (
    !$past(i_reset) |-> o_right_attack_own == $past(r_sh[7]))
    else $error("right own flag does not follow the select bit");
  right_time_a: assert property (
    !$past(i_reset) && o_right_attack_own
    |-> o_right_attack_ms == $past(r_raw))
    else $error("right attack is not baseline times factor");
  left_read_a: assert property (
    !$past(i_reset) && $past(i_rd) && $past(i_addr) == 8'h68
    |-> o_rdata == $past(l_sh))
    else $error("left register reads back wrong");
  right_read_a: assert property (
    !$past(i_reset) && $past(i_rd) && $past(i_addr) == 8'h69
    |-> o_rdata == $past(r_sh))
    else $error("right register reads back wrong");
  rdata_idle_a: assert property (
    !$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data not zero outside a read");
endmodule
bind atcs_top atcs_props atcs_props_inst (.*);
`default_nettype wire

/* sim/atcs_top_tb.sv */
// Purpose: Self-checking bench of the time-constant register bank.
// Assumes: Outputs settle two edges after a write or input change.
// Notes:   An integer model predicts every read and every output.
`timescale 1ns/1ps
`default_nettype none
module atcs_top_tb;
  localparam int DB[4] = '{50, 150, 250, 350};
  localparam int AB[4] = '{7, 8, 10, 11};
  localparam int LIM[16] = '{4000, 5600, 8000, 9600, 11200, 11200, 16000,
    16000, 19200, 22400, 22400, 22400, 22400, 22400, 22400, 22400};
  logic        i_clk = 1'b0, i_reset = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
  logic [7:0]  i_addr = 8'h00, i_wdata = 8'h00, o_rdata, m_l, m_r;
  logic [3:0]  i_adc_decimation_ratio = 4'h0;
  logic [15:0] i_legacy_left_decay = 16'h0000;
  logic [15:0] i_legacy_right_attack = 16'h0000;
  logic [15:0] o_left_decay_ms, o_right_attack_ms;
  logic        o_left_decay_own, o_left_decay_capped, o_right_attack_own;
  int          failures = 0, num_checks = 0, seed = 51, i;

  atcs_top atcs_top_inst (
    .i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .i_adc_decimation_ratio(i_adc_decimation_ratio),
    .i_legacy_left_decay(i_legacy_left_decay),
    .i_legacy_right_attack(i_legacy_right_attack), .o_rdata(o_rdata),
    .o_left_decay_ms(o_left_decay_ms), .o_left_decay_own(o_left_decay_own),
    .o_left_decay_capped(o_left_decay_capped),
    .o_right_attack_ms(o_right_attack_ms),
    .o_right_attack_own(o_right_attack_own));

  always #5 i_clk = ~i_clk;

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Limit applies to the own-field left path only.
  function automatic logic [15:0] l_time(input logic [7:0] c, output logic cap);
    int t;
    int lim;
    t = DB[c[6:5]] << c[4:2];
    lim = LIM[i_adc_decimation_ratio];
    cap = c[7] && t > lim;
    if (!c[7])
      return i_legacy_left_decay;
    return cap ? 16'(lim) : 16'(t);
  endfunction

  function automatic logic [15:0] r_time(input logic [7:0] c);
    return c[7] ? 16'(AB[c[6:5]] << c[4:2]) : i_legacy_right_attack;
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    if (a == 8'h68)
      m_l = d;
    if (a == 8'h69)
      m_r = d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a);
    logic [7:0] e;
    logic       cap;
    void'(l_time(m_l, cap));
    e = (a == 8'h68) ? m_l : (a == 8'h69) ? m_r : 8'h00;
    if (a == 8'h6a)
      e = {5'h00, m_r[7], m_l[7], cap};
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    chk("rdata", {8'h00, e}, {8'h00, o_rdata});
    @(posedge i_clk);
  endtask

  task automatic out_chk;
    logic cap;
    repeat (2) @(posedge i_clk);
    #1;
    chk("left_ms", l_time(m_l, cap), o_left_decay_ms);
    chk("left_cap", {15'h0000, cap}, {15'h0000, o_left_decay_capped});
    chk("left_own", {15'h0000, m_l[7]}, {15'h0000, o_left_decay_own});
    chk("right_ms", r_time(m_r), o_right_attack_ms);
    chk("right_own", {15'h0000, m_r[7]}, {15'h0000, o_right_attack_own});
    @(posedge i_clk);
  endtask

  task automatic close_out;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    #200000;
    failures++;
    close_out();
  end

  initial begin
    m_l = 8'h00;
    m_r = 8'h00;
    repeat (10) @(posedge i_clk);
    i_reset <= 1'b0;
    rd_chk(8'h68);
    rd_chk(8'h69);
    out_chk();
    // Every baseline and factor code in both selections, every ratio code.
    for (i = 0; i < 64; i++) begin
      i_legacy_left_decay <= 16'($random(seed));
      i_legacy_right_attack <= 16'($random(seed));
      i_adc_decimation_ratio <= i[3:0];
      wr(8'h68, {~i[5], i[4:0], 2'b00});
      @(posedge i_clk);
      wr(8'h69, {i[5] ^ i[0], i[2:0], i[4:3], 2'b00});
      out_chk();
    end
    wr(8'h68, 8'hfc);
    rd_chk(8'h68);
    rd_chk(8'h6a);
    rd_chk(8'h69);
    // The status word is read only; a write there must leave it alone.
    wr(8'h6a, 8'hff);
    rd_chk(8'h6a);
    wr(8'h70, 8'hff);
    rd_chk(8'h70);
    rd_chk(8'h68);
    i_reset <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_reset <= 1'b0;
    m_l = 8'h00;
    m_r = 8'h00;
    rd_chk(8'h68);
    rd_chk(8'h69);
    out_chk();
    close_out();
  end
endmodule
`default_nettype wire
